// [core/slil_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "slil_map.vh"

module slil_top #(
  parameter [`SLIL_FLASH_CNT_W-1:0] FLASH_HALF_CYCLES = `SLIL_FLASH_HALF_CYC
) (
  input  wire                    sys_clk,
  input  wire                    reset_n,
  // Register port
  input  wire [`SLIL_ADDR_W-1:0] reg_addr,
  input  wire [`SLIL_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`SLIL_DATA_W-1:0] reg_rdata,
  output wire                    irq,
  // Restart interlock and fields
  input  wire                    restart_interlock_enabled,
  input  wire                    restart_interlock_blocked,
  input  wire                    protective_field_occupied,
  input  wire                    linked_sensor_ok,
  input  wire                    four_field_mode,
  input  wire                    warn_field3_interrupted,
  input  wire                    warn_field2_interrupted,
  // Power and self test
  input  wire                    supply_ok,
  input  wire                    self_test_failed,
  input  wire                    internal_comm_error,
  input  wire                    identify_blink,
  // Safety protocol
  input  wire                    sp_initialised,
  input  wire                    sp_enabled,
  input  wire                    sp_passive,
  input  wire                    sp_active,
  input  wire                    sp_config_failed,
  input  wire                    sp_comm_error,
  // Fieldbus
  input  wire                    fb_initialising,
  input  wire                    fb_active,
  input  wire                    fb_cyclic_running,
  input  wire                    fb_config_failed,
  input  wire                    fb_no_data,
  input  wire                    fb_invalid_data,
  input  wire                    fb_topology_error,
  input  wire                    fb_bus_error,
  // Ethernet ports
  input  wire                    port_a_link,
  input  wire                    port_a_activity,
  input  wire                    port_b_link,
  input  wire                    port_b_activity,
  // Lamp drives
  output reg                     restart_interlock_yellow,
  output reg                     warn3_blue,
  output reg                     warn2_yellow,
  output reg                     power_indicator_red,
  output reg                     power_indicator_green,
  output reg                     safety_protocol_indicator_red,
  output reg                     safety_protocol_indicator_green,
  output reg                     net_indicator_red,
  output reg                     net_indicator_green,
  output wire                    port_a_link_activity_indicator_green,
  output wire                    port_a_link_activity_indicator_orange,
  output wire                    port_b_link_activity_indicator_green,
  output wire                    port_b_link_activity_indicator_orange
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [`SLIL_FLASH_CNT_W-1:0] flash_cnt_q;
  reg                          flash_phase_q;
  wire [`SLIL_FLASH_CNT_W-1:0] flash_last;
  wire                         flash_tick;

  reg                          lamp_test_q;
  reg  [`SLIL_IRQ_W-1:0]       irq_stat_q;
  reg  [`SLIL_IRQ_W-1:0]       irq_stat_d;
  reg  [`SLIL_IRQ_W-1:0]       irq_mask_q;
  reg  [`SLIL_IRQ_W-1:0]       err_prev_q;
  wire [`SLIL_IRQ_W-1:0]       err_now;
  wire [`SLIL_IRQ_W-1:0]       err_rise;
  wire [`SLIL_STAT_W-1:0]      lamp_state;
  reg  [`SLIL_DATA_W-1:0]      rdata_d;

  wire                         wr_ctrl;
  wire                         wr_irq_stat;
  wire                         wr_irq_mask;

  wire                         pwr_err;
  wire                         sp_err;
  wire                         net_err;
  wire                         warn_evt;

  reg                          ri_yellow_d;
  reg                          w3_blue_d;
  reg                          w2_yellow_d;
  reg                          pwr_red_d;
  reg                          pwr_green_d;
  reg                          sp_red_d;
  reg                          sp_green_d;
  reg                          net_red_d;
  reg                          net_green_d;

  // ----------------------------------------
  // Shared flash divider
  // ----------------------------------------
  // One counter for every lamp keeps all flashing in step; the
  // half period is a parameter so simulation can shorten it.
  assign flash_last = FLASH_HALF_CYCLES - {{(`SLIL_FLASH_CNT_W-1){1'b0}}, 1'b1};
  assign flash_tick = (flash_cnt_q == flash_last);

  // Free-running count and phase toggle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_q   <= {`SLIL_FLASH_CNT_W{1'b0}};
      flash_phase_q <= 1'b0;
    end else if (flash_tick) begin
      flash_cnt_q   <= {`SLIL_FLASH_CNT_W{1'b0}};
      flash_phase_q <= !flash_phase_q;
    end else begin
      flash_cnt_q   <= flash_cnt_q + {{(`SLIL_FLASH_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Restart interlock and warning field lamps
  // ----------------------------------------
  // Occupied field flashes; blocked but free field is steady only while linked_sensor_ok is high
  always @* begin
    ri_yellow_d = 1'b0;
    if (!restart_interlock_enabled) begin
      ri_yellow_d = 1'b0;
    end else if (protective_field_occupied) begin
      ri_yellow_d = flash_phase_q;
    end else if (restart_interlock_blocked && linked_sensor_ok) begin
      ri_yellow_d = 1'b1;
    end else begin
      ri_yellow_d = 1'b0;
    end
  end

  // Second and third lamps only carry meaning in four-field mode
  always @* begin
    w3_blue_d   = four_field_mode && warn_field3_interrupted;
    w2_yellow_d = four_field_mode && warn_field2_interrupted && flash_phase_q;
  end

  // ----------------------------------------
  // Power lamp
  // ----------------------------------------
  // Internal fault outranks identify blink and healthy green
  always @* begin
    pwr_red_d   = 1'b0;
    pwr_green_d = 1'b0;
    if (!supply_ok) begin
      pwr_green_d = 1'b0;
    end else if (self_test_failed || internal_comm_error) begin
      pwr_red_d   = 1'b1;
    end else if (identify_blink) begin
      pwr_green_d = flash_phase_q;
    end else begin
      pwr_green_d = 1'b1;
    end
  end

  // ----------------------------------------
  // Safety protocol lamp
  // ----------------------------------------
  // Errors are tested first so a faulty link never reads as idle
  always @* begin
    sp_red_d   = 1'b0;
    sp_green_d = 1'b0;
    if (sp_comm_error) begin
      sp_red_d   = 1'b1;
    end else if (sp_config_failed) begin
      sp_red_d   = flash_phase_q;
    end else if (!sp_initialised || !sp_enabled) begin
      sp_green_d = 1'b0;
    end else if (sp_passive || identify_blink) begin
      sp_green_d = flash_phase_q;
    end else if (sp_active) begin
      sp_green_d = 1'b1;
    end else begin
      sp_green_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Network lamp
  // ----------------------------------------
  // Orange is red and green lit together
  always @* begin
    net_red_d   = 1'b0;
    net_green_d = 1'b0;
    if (fb_bus_error) begin
      net_red_d   = 1'b1;
    end else if (fb_config_failed || fb_no_data || fb_invalid_data) begin
      net_red_d   = flash_phase_q;
    end else if (fb_topology_error) begin
      net_red_d   = flash_phase_q;
      net_green_d = flash_phase_q;
    end else if (fb_initialising || identify_blink) begin
      net_green_d = flash_phase_q;
    end else if (fb_active && fb_cyclic_running) begin
      net_green_d = 1'b1;
    end else begin
      net_green_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Registered lamp drives
  // ----------------------------------------
  // Lamp test lights every segment so an operator can spot a dead one
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_interlock_yellow        <= 1'b0;
      warn3_blue                      <= 1'b0;
      warn2_yellow                    <= 1'b0;
      power_indicator_red             <= 1'b0;
      power_indicator_green           <= 1'b0;
      safety_protocol_indicator_red   <= 1'b0;
      safety_protocol_indicator_green <= 1'b0;
      net_indicator_red               <= 1'b0;
      net_indicator_green             <= 1'b0;
    end else begin
      restart_interlock_yellow        <= ri_yellow_d | lamp_test_q;
      warn3_blue                      <= w3_blue_d   | lamp_test_q;
      warn2_yellow                    <= w2_yellow_d | lamp_test_q;
      power_indicator_red             <= pwr_red_d   | lamp_test_q;
      power_indicator_green           <= pwr_green_d | lamp_test_q;
      safety_protocol_indicator_red   <= sp_red_d    | lamp_test_q;
      safety_protocol_indicator_green <= sp_green_d  | lamp_test_q;
      net_indicator_red               <= net_red_d   | lamp_test_q;
      net_indicator_green             <= net_green_d | lamp_test_q;
    end
  end

  // ----------------------------------------
  // Ethernet port lamps
  // ----------------------------------------
  slil_port_led u_port_a (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .link_up     (port_a_link),
    .activity    (port_a_activity),
    .flash_phase (flash_phase_q),
    .lamp_test   (lamp_test_q),
    .green_q     (port_a_link_activity_indicator_green),
    .orange_q    (port_a_link_activity_indicator_orange)
  );

  slil_port_led u_port_b (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .link_up     (port_b_link),
    .activity    (port_b_activity),
    .flash_phase (flash_phase_q),
    .lamp_test   (lamp_test_q),
    .green_q     (port_b_link_activity_indicator_green),
    .orange_q    (port_b_link_activity_indicator_orange)
  );

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // Rising edge of each fault group raises an interrupt event
  assign pwr_err  = supply_ok && (self_test_failed || internal_comm_error);
  assign sp_err   = sp_comm_error || sp_config_failed;
  assign net_err  = fb_bus_error || fb_config_failed || fb_no_data ||
                    fb_invalid_data || fb_topology_error;
  assign warn_evt = four_field_mode && (warn_field2_interrupted || warn_field3_interrupted);

  assign err_now  = {warn_evt, net_err, sp_err, pwr_err};
  assign err_rise = err_now & ~err_prev_q;

  // Previous fault levels for edge detection
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_prev_q <= `SLIL_IRQ_RST;
    end else begin
      err_prev_q <= err_now;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_ctrl     = reg_wr && (reg_addr == `SLIL_REG_CTRL);
  assign wr_irq_stat = reg_wr && (reg_addr == `SLIL_REG_IRQ_STAT);
  assign wr_irq_mask = reg_wr && (reg_addr == `SLIL_REG_IRQ_MASK);

  // Write one to clear; a new event in the same cycle wins
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_irq_stat) begin
      irq_stat_d = irq_stat_d & ~reg_wdata[`SLIL_IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | err_rise;
  end

  // Control, mask and sticky status storage
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_test_q <= `SLIL_CTRL_RST;
      irq_mask_q  <= `SLIL_IRQ_RST;
      irq_stat_q  <= `SLIL_IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        lamp_test_q <= reg_wdata[`SLIL_CTRL_LAMP_TEST];
      end
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata[`SLIL_IRQ_W-1:0];
      end
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  assign lamp_state = {flash_phase_q,
                       port_b_link_activity_indicator_orange,
                       port_b_link_activity_indicator_green,
                       port_a_link_activity_indicator_orange,
                       port_a_link_activity_indicator_green,
                       net_indicator_green,
                       net_indicator_red,
                       safety_protocol_indicator_green,
                       safety_protocol_indicator_red,
                       power_indicator_green,
                       power_indicator_red,
                       warn2_yellow,
                       warn3_blue,
                       restart_interlock_yellow};

  // Unmapped addresses and idle cycles read as zero
  always @* begin
    rdata_d = {`SLIL_DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `SLIL_REG_CTRL: begin
          rdata_d[`SLIL_CTRL_LAMP_TEST] = lamp_test_q;
        end
        `SLIL_REG_STAT: begin
          rdata_d[`SLIL_STAT_W-1:0] = lamp_state;
        end
        `SLIL_REG_IRQ_STAT: begin
          rdata_d[`SLIL_IRQ_W-1:0] = irq_stat_q;
        end
        `SLIL_REG_IRQ_MASK: begin
          rdata_d[`SLIL_IRQ_W-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = {`SLIL_DATA_W{1'b0}};
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= {`SLIL_DATA_W{1'b0}};
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// [inc/slil_map.vh]
`ifndef SLIL_MAP_VH
`define SLIL_MAP_VH

// ----------------------------------------
// Clock and flash timing
// ----------------------------------------
// System clock rate in kHz (200 MHz)
`define SLIL_CLK_KHZ        200000
// Half period of every flashing pattern, in ms
`define SLIL_FLASH_HALF_MS  250
// Half period in clock cycles, derived from the two figures above
`define SLIL_FLASH_HALF_CYC (`SLIL_FLASH_HALF_MS * `SLIL_CLK_KHZ)
// Width of the flash divider counter
`define SLIL_FLASH_CNT_W    26

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SLIL_ADDR_W         8
`define SLIL_DATA_W         32
`define SLIL_REG_CTRL       8'h00
`define SLIL_REG_STAT       8'h04
`define SLIL_REG_IRQ_STAT   8'h08
`define SLIL_REG_IRQ_MASK   8'h0C

// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define SLIL_CTRL_LAMP_TEST 0
`define SLIL_CTRL_RST       1'h0

// ----------------------------------------
// Interrupt status / mask layout
// ----------------------------------------
`define SLIL_IRQ_W          4
`define SLIL_IRQ_PWR_ERR    0
`define SLIL_IRQ_SP_ERR     1
`define SLIL_IRQ_NET_ERR    2
`define SLIL_IRQ_WARN       3
`define SLIL_IRQ_RST        4'h0

// ----------------------------------------
// Indicator state register layout
// ----------------------------------------
`define SLIL_STAT_W         14
`define SLIL_STAT_RST       14'h0000

`endif

// [core/slil_port_led.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Link/activity indicator for one Ethernet port
// ----------------------------------------
module slil_port_led (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire link_up,
  input  wire activity,
  input  wire flash_phase,
  input  wire lamp_test,
  output reg  green_q,
  output reg  orange_q
);

  reg green_d;
  reg orange_d;

  // No link wins over activity, so a dead port never flickers
  always @* begin
    green_d  = 1'b0;
    orange_d = 1'b0;
    if (lamp_test) begin
      green_d  = 1'b1;
      orange_d = 1'b1;
    end else if (!link_up) begin
      green_d  = 1'b0;
      orange_d = 1'b0;
    end else if (activity) begin
      green_d  = flash_phase;
      orange_d = !flash_phase;
    end else begin
      green_d  = 1'b1;
    end
  end

  // Registered lamp drive
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      green_q  <= 1'b0;
      orange_q <= 1'b0;
    end else begin
      green_q  <= green_d;
      orange_q <= orange_d;
    end
  end

endmodule

`default_nettype wire

// [bench/slil_panel.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Front panel as an operator sees it
// ----
module slil_panel (
  input  wire logic        sys_clk,
  input  wire logic        clr,
  input  wire logic [12:0] lamp,
  output var  logic [12:0] seen_on_q,
  output var  logic [12:0] seen_off_q
);
  // Lit and dark since last clear; both seen means flashing
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      seen_on_q  <= 13'h0;
      seen_off_q <= 13'h0;
    end else begin
      seen_on_q  <= seen_on_q | lamp;
      seen_off_q <= seen_off_q | ~lamp;
    end
  end
endmodule
`default_nettype wire

// [bench/slil_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Lamp decode checker
// ----
module slil_checker #(
  parameter [25:0] FLASH_HALF_CYCLES = 26'h4
) (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        restart_interlock_enabled,
  input wire logic        restart_interlock_yellow,
  input wire logic        supply_ok,
  input wire logic        self_test_failed,
  input wire logic        power_indicator_red,
  input wire logic        power_indicator_green,
  input wire logic        sp_comm_error,
  input wire logic        safety_protocol_indicator_red,
  input wire logic        safety_protocol_indicator_green,
  input wire logic        fb_bus_error,
  input wire logic        net_indicator_red,
  input wire logic        net_indicator_green,
  input wire logic        port_a_link,
  input wire logic        port_a_activity,
  input wire logic        port_b_link,
  input wire logic        port_b_activity,
  input wire logic        port_a_link_activity_indicator_green,
  input wire logic        port_a_link_activity_indicator_orange,
  input wire logic        port_b_link_activity_indicator_green,
  input wire logic        port_b_link_activity_indicator_orange
);
  logic lt_q;
  logic lt2_q;
  wire  lt = lt_q | lt2_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Lamp test mirror; lamps lag the register, so two stages are masked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lt_q  <= 1'b0;
      lt2_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) lt_q <= reg_wdata[0];
      lt2_q <= lt_q;
    end
  end
  property p_ri_dark;
    !restart_interlock_enabled |=> lt || !restart_interlock_yellow;
  endproperty
  a_ri_dark: assert property (p_ri_dark)
    else $error("restart lamp lit while interlock off");
  property p_pwr_red;
    supply_ok && self_test_failed |=> power_indicator_red && (lt || !power_indicator_green);
  endproperty
  a_pwr_red: assert property (p_pwr_red)
    else $error("power lamp not red on self test fault");
  property p_sp_red;
    sp_comm_error |=> safety_protocol_indicator_red && (lt || !safety_protocol_indicator_green);
  endproperty
  a_sp_red: assert property (p_sp_red)
    else $error("protocol lamp not red on comm error");
  property p_net_red;
    fb_bus_error |=> net_indicator_red && (lt || !net_indicator_green);
  endproperty
  a_net_red: assert property (p_net_red)
    else $error("network lamp not red on bus error");
  property p_pa_dark;
    !port_a_link |=> lt || !(port_a_link_activity_indicator_green
                             || port_a_link_activity_indicator_orange);
  endproperty
  a_pa_dark: assert property (p_pa_dark)
    else $error("port a lamp lit without link");
  property p_pb_idle;
    port_b_link && !port_b_activity |=> port_b_link_activity_indicator_green
                                        && (lt || !port_b_link_activity_indicator_orange);
  endproperty
  a_pb_idle: assert property (p_pb_idle)
    else $error("port b lamp not steady green when idle");
  property p_pa_alt;
    (port_a_link && port_a_activity)[*2] |=>
      lt || (port_a_link_activity_indicator_green != port_a_link_activity_indicator_orange);
  endproperty
  a_pa_alt: assert property (p_pa_alt)
    else $error("port a lamp colours not alternating");
  property p_in_phase;
    (port_a_link && port_a_activity && port_b_link && port_b_activity)[*2] |=>
      port_a_link_activity_indicator_green == port_b_link_activity_indicator_green;
  endproperty
  a_in_phase: assert property (p_in_phase)
    else $error("port lamps flashing out of phase");
  c_alt: cover property (port_a_activity && port_a_link ##1 port_a_link_activity_indicator_orange);
  c_lt: cover property (lt_q);
  c_net: cover property (fb_bus_error ##1 net_indicator_red);
endmodule
bind slil_top slil_checker #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) slil_checker_inst (
  .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .restart_interlock_enabled,
  .restart_interlock_yellow, .supply_ok, .self_test_failed, .power_indicator_red,
  .power_indicator_green, .sp_comm_error, .safety_protocol_indicator_red,
  .safety_protocol_indicator_green, .fb_bus_error, .net_indicator_red, .net_indicator_green,
  .port_a_link, .port_a_activity, .port_b_link, .port_b_activity,
  .port_a_link_activity_indicator_green, .port_a_link_activity_indicator_orange,
  .port_b_link_activity_indicator_green, .port_b_link_activity_indicator_orange);
`default_nettype wire

// [bench/slil_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench top
// ----
module slil_top_test;
  logic        sys_clk;
  logic        reset_n;
  logic [7:0]  ra;
  logic [31:0] wd;
  logic        wr;
  logic        rd;
  logic        clr;
  logic [28:0] v;
  logic [28:0] x;
  logic [31:0] r;
  wire  [31:0] rdata;
  wire         irq;
  wire  [12:0] l;
  wire  [12:0] on;
  wire  [12:0] off;
  int          n_mismatch;
  int          n_checks;

  // Short flash period keeps each observation to a few cycles
  slil_top #(.FLASH_HALF_CYCLES(26'h4)) slil_top_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .irq(irq), .restart_interlock_enabled(v[0]),
    .restart_interlock_blocked(v[1]), .protective_field_occupied(v[2]),
    .linked_sensor_ok(v[3]), .four_field_mode(v[4]), .warn_field3_interrupted(v[5]),
    .warn_field2_interrupted(v[6]), .supply_ok(v[7]), .self_test_failed(v[8]),
    .internal_comm_error(v[9]), .identify_blink(v[10]), .sp_initialised(v[11]),
    .sp_enabled(v[12]), .sp_passive(v[13]), .sp_active(v[14]), .sp_config_failed(v[15]),
    .sp_comm_error(v[16]), .fb_initialising(v[17]), .fb_active(v[18]),
    .fb_cyclic_running(v[19]), .fb_config_failed(v[20]), .fb_no_data(v[21]),
    .fb_invalid_data(v[22]), .fb_topology_error(v[23]), .fb_bus_error(v[24]),
    .port_a_link(v[25]), .port_a_activity(v[26]), .port_b_link(v[27]), .port_b_activity(v[28]),
    .restart_interlock_yellow(l[0]), .warn3_blue(l[1]), .warn2_yellow(l[2]),
    .power_indicator_red(l[3]), .power_indicator_green(l[4]),
    .safety_protocol_indicator_red(l[5]), .safety_protocol_indicator_green(l[6]),
    .net_indicator_red(l[7]), .net_indicator_green(l[8]),
    .port_a_link_activity_indicator_green(l[9]), .port_a_link_activity_indicator_orange(l[10]),
    .port_b_link_activity_indicator_green(l[11]), .port_b_link_activity_indicator_orange(l[12]));

  slil_panel slil_panel_inst (.sys_clk(sys_clk), .clr(clr), .lamp(l), .seen_on_q(on),
                              .seen_off_q(off));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Expected lamp classes, two bits each: 0 dark, 1 steady, 2 flashing
  function automatic logic [25:0] model(input logic [28:0] s);
    logic [1:0]  c [13];
    logic [25:0] m;
    for (int i = 0; i < 13; i++) c[i] = 2'h0;
    if (s[0]) c[0] = s[2] ? 2'h2 : {1'b0, s[1] & s[3]};
    c[1] = {1'b0, s[4] & s[5]};
    c[2] = {s[4] & s[6], 1'b0};
    if (s[7] && (s[8] || s[9])) c[3] = 2'h1;
    else if (s[7]) c[4] = s[10] ? 2'h2 : 2'h1;
    if (s[16]) c[5] = 2'h1;
    else if (s[15]) c[5] = 2'h2;
    else if (s[11] && s[12]) c[6] = (s[13] || s[10]) ? 2'h2 : {1'b0, s[14]};
    if (s[24]) c[7] = 2'h1;
    else if (s[20] || s[21] || s[22]) c[7] = 2'h2;
    else if (s[23]) {c[7], c[8]} = 4'hA;
    else c[8] = (s[17] || s[10]) ? 2'h2 : {1'b0, s[18] & s[19]};
    if (s[25]) {c[9], c[10]} = s[26] ? 4'hA : 4'h4;
    if (s[27]) {c[11], c[12]} = s[28] ? 4'hA : 4'h4;
    for (int i = 0; i < 13; i++) m[2*i +: 2] = c[i];
    return m;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask

  // Settle, then watch two full flash periods on the panel
  task automatic look(input logic [25:0] e);
    logic [25:0] c;
    repeat (2) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 13; i++) c[2*i +: 2] = on[i] ? (off[i] ? 2'h2 : 2'h1) : 2'h0;
    chk("lamps", {6'h0, e}, {6'h0, c});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    {reset_n, ra, wd, wr, rd, clr, v} = '0;
    n_mismatch = 0;
    n_checks = 0;
    r = 32'hA9A53DED;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rreg(8'h0C, 32'h0, "irq_mask");
    rreg(8'h10, 32'h0, "unmapped");
    // Random states; faults thinned so lower priorities also show
    for (int t = 0; t < 200; t++) begin
      r = lfsr(r);
      x = r[28:0];
      r = lfsr(lfsr(r));
      x = x & ~(r[28:0] & 29'h1F18300);
      @(posedge sys_clk);
      v <= x;
      look(model(x));
    end
    wreg(8'h00, 32'h1);
    look(26'h1555555);
    rreg(8'h00, 32'h1, "ctrl");
    wreg(8'h00, 32'h0);
    // Interrupt: raise, clear, then masked and unmasked
    @(posedge sys_clk);
    v <= 29'h80;
    wreg(8'h08, 32'hF);
    wreg(8'h0C, 32'h4);
    rreg(8'h08, 32'h0, "irq_stat");
    @(posedge sys_clk);
    v <= 29'h1000080;
    rreg(8'h08, 32'h4, "irq_stat");
    chk("irq", 32'h1, {31'h0, irq});
    wreg(8'h08, 32'h4);
    rreg(8'h08, 32'h0, "irq_stat");
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge sys_clk);
    v <= 29'h10001F0;
    rreg(8'h08, 32'h9, "irq_stat");
    chk("irq", 32'h0, {31'h0, irq});
    wreg(8'h0C, 32'hF);
    @(posedge sys_clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    summarize();
  end
endmodule
`default_nettype wire
